// ### inc/asa_pkg.sv
/*
  Shared constants and carriers for the axis stop arbiter.
  Assumes a 250 MHz system clock and a 32-bit classic Wishbone register bus.
*/
package asa_pkg;
  localparam int AXES = 4;                     // Axes handled by one arbiter
  localparam int CLK_MHZ = 250;                // System clock rate
  localparam int SYS_DEC_MS = 1;               // Fixed system stop deceleration
  localparam logic [13:0] DEC_MS_RST = 14'h0064; // 100 ms after reset
  localparam logic [13:0] DEC_MS_MAX = 14'h2710; // 10000 ms ceiling
  // Register byte offsets
  localparam logic [9:0] OFS_CTRL = 10'h000;
  localparam logic [9:0] OFS_STAT = 10'h004;
  localparam logic [9:0] OFS_EMG = 10'h008;
  localparam logic [9:0] OFS_DEC = 10'h00C;
  localparam logic [9:0] OFS_JOG = 10'h010;
  localparam logic [9:0] OFS_START = 10'h014;
  localparam logic [9:0] OFS_GROUP = 10'h018;
  localparam logic [9:0] OFS_FLAGS = 10'h01C;
  localparam logic [9:0] OFS_MOVE = 10'h020;
  localparam logic [9:0] OFS_DWELL = 10'h024;
  localparam logic [9:0] OFS_NDEC = 10'h028;
  localparam logic [9:0] OFS_EDEC = 10'h040; // + 4 * axis
  localparam logic [9:0] OFS_LDEC = 10'h080; // + 4 * axis
  localparam logic [9:0] OFS_RDEC = 10'h0C0; // + 4 * axis
  localparam logic [9:0] OFS_POS = 10'h100;  // + 4 * axis
  // CTRL fields and reset values
  localparam int CTRL_MODE = 0;
  localparam int CTRL_ERRALL = 1;
  localparam int CTRL_PROG = 2;                // Two bits
  localparam int CTRL_NOTE = 4;
  localparam logic [4:0] CTRL_RST = 5'h16;     // Notify on, prog decel, all axes stop
  localparam int START_OP = 16;                // Two-bit operation kind in START
  localparam int FLAGS_DONE = 16;              // Done flags sit above busy flags
  localparam int STAT_ERR = 1;

  typedef enum logic [1:0] {
    ASA_OP_POS = 2'h0,
    ASA_OP_JOG = 2'h1,
    ASA_OP_HOME = 2'h2
  } asa_op_type;

  typedef enum logic [1:0] {
    ASA_PROG_RUN = 2'h0,
    ASA_PROG_DEC = 2'h1,
    ASA_PROG_EMG = 2'h2
  } asa_prog_type;

  typedef enum logic [2:0] {
    ASA_C_NONE = 3'h0,
    ASA_C_SYS = 3'h1,
    ASA_C_LIM = 3'h2,
    ASA_C_SLIM = 3'h3,
    ASA_C_ERR = 3'h4,
    ASA_C_EMG = 3'h5,
    ASA_C_DEC = 3'h6,
    ASA_C_PROG = 3'h7
  } asa_cause_type;

  // Gray coded along idle, run, decel, hold; pause and dwell branch off
  typedef enum logic [2:0] {
    ASA_S_IDLE = 3'h0,
    ASA_S_RUN = 3'h1,
    ASA_S_DECEL = 3'h3,
    ASA_S_HOLD = 3'h2,
    ASA_S_PDEC = 3'h5,
    ASA_S_PAUSED = 3'h4,
    ASA_S_DWELL = 3'h7
  } asa_state_type;

  typedef struct packed {
    asa_state_type st;
    asa_op_type op;
    asa_cause_type cause;
    logic handoff;
    logic busy;
    logic done;
    logic paused;
    logic [31:0] cnt;
    logic [31:0] left;
    logic [31:0] pos;
    logic [13:0] edec;
    logic [13:0] ldec;
    logic [13:0] rdec;
  } asa_axis_type;

  typedef struct packed {
    asa_axis_type [AXES-1:0] ax;
    logic [4:0] ctrl;
    logic mode_eff;
    logic err_flag;
    logic note;
    logic cpu_run_prev;
    logic [AXES-1:0] emg;
    logic [AXES-1:0] dec;
    logic [AXES-1:0] dec_prev;
    logic [AXES-1:0] jog;
    logic [AXES-1:0] link;
    logic [31:0] move_len;
    logic [31:0] dwell;
    logic [13:0] ndec;
    logic ack;
    logic [31:0] rdat;
  } asa_state_all_type;
endpackage

// ### rtl/asa_top.sv
/*
  Axis stop arbiter: resolves stop causes per axis, runs deceleration timers,
  pause and dwell, and keeps busy, done and position for each axis.
  Assumes a classic Wishbone master and synchronous limit, fault and mode pins.
*/
`timescale 1ns/1ps
`default_nettype none
module asa_top #(
  parameter int CYC_PER_MS = 1000 * asa_pkg::CLK_MHZ
) (
  // Clock and reset
  input wire logic sys_clk,
  input wire logic rst_b,
  // Wishbone slave
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_we_i,
  input wire logic [9:0] wb_adr_i,
  input wire logic [3:0] wb_sel_i,
  input wire logic [31:0] wb_dat_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  // Stop conditions and host mode
  input wire logic system_halt_request_output,
  input wire logic [asa_pkg::AXES-1:0] limit_hit,
  input wire logic [asa_pkg::AXES-1:0] soft_limit_hit,
  input wire logic [asa_pkg::AXES-1:0] axis_fault,
  input wire logic [asa_pkg::AXES-1:0] creep_reached,
  input wire logic cpu_run,
  // Axis status
  output logic [asa_pkg::AXES-1:0] axis_busy,
  output logic [asa_pkg::AXES-1:0] axis_done,
  output logic [asa_pkg::AXES-1:0] axis_paused,
  output logic [asa_pkg::AXES-1:0] servo_handoff,
  output logic error_notify
);
  localparam int N = asa_pkg::AXES;

  asa_pkg::asa_state_all_type s_q, s_d;

  // Cycles for a deceleration time given in milliseconds
  function automatic logic [31:0] ms_cyc(input logic [13:0] ms);
    ms_cyc = 32'(ms) * 32'(CYC_PER_MS);
  endfunction

  // Byte-lane merge of a bus write into a stored word
  function automatic logic [31:0] lane(input logic [31:0] old, input logic [31:0] nw,
                                       input logic [3:0] sel);
    for (int b = 0; b < 4; b++) begin
      old[8*b +: 8] = sel[b] ? nw[8*b +: 8] : old[8*b +: 8];
    end
    lane = old;
  endfunction

  // Lowest axis of the linked group that holds axis a
  function automatic int leader(input logic [N-1:0] link, input int a);
    leader = a;
    for (int k = N - 1; k > 0; k--) begin
      if (k <= leader && link[k] && leader == k) begin
        leader = k - 1;
      end
    end
  endfunction

  // Clamp a programmed time to its legal range
  function automatic logic [13:0] clamp(input logic [31:0] v);
    clamp = (v > 32'(asa_pkg::DEC_MS_MAX)) ? asa_pkg::DEC_MS_MAX : v[13:0];
  endfunction

  logic [31:0] sys_cyc;
  assign sys_cyc = 32'(asa_pkg::SYS_DEC_MS * CYC_PER_MS);

  always_comb begin
    logic req, wr_go, rd_go, any_fault, all_still, prog_evt, hit;
    logic [N-1:0] lim_g, slim_g, err_g, emg_g, dec_g, dec_rise;
    logic [N-1:0] start_hit;
    logic [31:0] rd;
    logic [9:0] adr;
    asa_pkg::asa_cause_type c;
    int ld;
    all_still = 1'b1;
    prog_evt = 1'b0;
    hit = 1'b0;
    lim_g = '0;
    slim_g = '0;
    err_g = '0;
    emg_g = '0;
    dec_g = '0;
    dec_rise = '0;
    c = asa_pkg::ASA_C_NONE;
    ld = 0;
    s_d = s_q;
    rd = 32'h0000_0000;
    adr = wb_adr_i;
    req = wb_cyc_i && wb_stb_i;
    wr_go = req && wb_we_i && s_q.ack;
    rd_go = req && !wb_we_i && !s_q.ack;
    start_hit = '0;
    any_fault = |axis_fault;
    // Register writes: control, per-axis request words, start commands, group, move, dwell and stop times
    if (wr_go) begin
      unique case (adr)
        asa_pkg::OFS_CTRL: s_d.ctrl = 5'(lane(32'(s_q.ctrl), wb_dat_i, wb_sel_i));
        asa_pkg::OFS_EMG: s_d.emg = N'(lane(32'(s_q.emg), wb_dat_i, wb_sel_i));
        asa_pkg::OFS_DEC: s_d.dec = N'(lane(32'(s_q.dec), wb_dat_i, wb_sel_i));
        asa_pkg::OFS_JOG: s_d.jog = N'(lane(32'(s_q.jog), wb_dat_i, wb_sel_i));
        asa_pkg::OFS_START: start_hit = wb_dat_i[N-1:0];
        asa_pkg::OFS_GROUP: s_d.link = N'(lane(32'(s_q.link), wb_dat_i, wb_sel_i));
        asa_pkg::OFS_MOVE: s_d.move_len = lane(s_q.move_len, wb_dat_i, wb_sel_i);
        asa_pkg::OFS_DWELL: s_d.dwell = lane(s_q.dwell, wb_dat_i, wb_sel_i);
        asa_pkg::OFS_NDEC: s_d.ndec = clamp(lane(32'(s_q.ndec), wb_dat_i, wb_sel_i));
        default: ;
      endcase
      for (int i = 0; i < N; i++) begin
        if (adr == asa_pkg::OFS_EDEC + 10'(4 * i)) begin
          s_d.ax[i].edec = clamp(lane(32'(s_q.ax[i].edec), wb_dat_i, wb_sel_i));
        end
        if (adr == asa_pkg::OFS_LDEC + 10'(4 * i)) begin
          s_d.ax[i].ldec = clamp(lane(32'(s_q.ax[i].ldec), wb_dat_i, wb_sel_i));
        end
        if (adr == asa_pkg::OFS_RDEC + 10'(4 * i)) begin
          s_d.ax[i].rdec = clamp(lane(32'(s_q.ax[i].rdec), wb_dat_i, wb_sel_i));
        end
      end
    end
    // Group resolution: emergency and decel requests come from the leader, conditions from any member
    for (int i = 0; i < N; i++) begin
      ld = leader(s_q.link, i);
      // Leader bit stands for the group
      emg_g[i] = s_q.emg[ld];
      dec_g[i] = s_q.dec[ld];
      dec_rise[i] = s_q.dec[ld] && !s_q.dec_prev[ld];
      lim_g[i] = 1'b0;
      slim_g[i] = 1'b0;
      err_g[i] = 1'b0;
      for (int j = 0; j < N; j++) begin
        // Any member's condition stops the group
        if (leader(s_q.link, j) == ld) begin
          lim_g[i] = lim_g[i] | limit_hit[j];
          slim_g[i] = slim_g[i] | soft_limit_hit[j];
          err_g[i] = err_g[i] | axis_fault[j];
        end
      end
      // All-axes reaction spreads a fault to every axis
      if (s_q.ctrl[asa_pkg::CTRL_ERRALL] && any_fault) begin
        err_g[i] = 1'b1;
      end
    end
    // Host leaving run mode is a one-clock event
    prog_evt = s_q.cpu_run_prev && !cpu_run &&
               s_q.ctrl[asa_pkg::CTRL_PROG +: 2] != 2'(asa_pkg::ASA_PROG_RUN);
    s_d.cpu_run_prev = cpu_run;
    s_d.dec_prev = s_q.dec;
    all_still = 1'b1;
    // Every axis resolved in each clock
    for (int i = 0; i < N; i++) begin
      if (system_halt_request_output) c = asa_pkg::ASA_C_SYS;
      else if (lim_g[i]) c = asa_pkg::ASA_C_LIM;
      else if (slim_g[i]) c = asa_pkg::ASA_C_SLIM;
      else if (err_g[i]) c = asa_pkg::ASA_C_ERR;
      else if (emg_g[i]) c = asa_pkg::ASA_C_EMG;
      else if (dec_g[i]) c = asa_pkg::ASA_C_DEC;
      else c = asa_pkg::ASA_C_NONE;
      hit = c != asa_pkg::ASA_C_NONE && c != asa_pkg::ASA_C_DEC;
      unique case (s_q.ax[i].st)
        asa_pkg::ASA_S_IDLE: begin
          // Start refused while any cause is active
          if (start_hit[i] && c == asa_pkg::ASA_C_NONE) begin
            s_d.ax[i].st = asa_pkg::ASA_S_RUN;
            s_d.ax[i].op = asa_pkg::asa_op_type'(wb_dat_i[asa_pkg::START_OP +: 2]);
            s_d.ax[i].left = s_q.move_len;
            s_d.ax[i].busy = 1'b1;
            s_d.ax[i].done = 1'b0;
            s_d.ax[i].cause = asa_pkg::ASA_C_NONE;
          end
        end
        asa_pkg::ASA_S_RUN, asa_pkg::ASA_S_PDEC, asa_pkg::ASA_S_PAUSED: begin
          if (s_q.ax[i].st != asa_pkg::ASA_S_PAUSED) begin
            // Position advances while the axis moves
            s_d.ax[i].pos = s_q.ax[i].pos + 32'h0000_0001;
          end
          if (s_q.ax[i].handoff) begin
            // Servo owns the motion; stop causes have no effect here
            if (!creep_reached[i]) begin
              s_d.ax[i].st = asa_pkg::ASA_S_IDLE;
              s_d.ax[i].handoff = 1'b0;
              s_d.ax[i].busy = 1'b0;
              s_d.ax[i].done = 1'b1;
            end
          end else if (c == asa_pkg::ASA_C_SYS) begin
            // Flags settle at once; fixed short ramp; pause dropped
            s_d.ax[i].st = asa_pkg::ASA_S_DECEL;
            s_d.ax[i].cnt = sys_cyc;
            s_d.ax[i].cause = c;
            s_d.ax[i].busy = 1'b0;
            s_d.ax[i].done = 1'b1;
          end else if (hit) begin
            // Stop with its own time; flags wait for the end; pause dropped
            s_d.ax[i].st = asa_pkg::ASA_S_DECEL;
            s_d.ax[i].cause = c;
            unique case (c)
              asa_pkg::ASA_C_LIM: s_d.ax[i].cnt = ms_cyc(s_q.ax[i].ldec);
              asa_pkg::ASA_C_EMG: s_d.ax[i].cnt = ms_cyc(s_q.ax[i].edec);
              default: s_d.ax[i].cnt = ms_cyc(s_q.ax[i].rdec);
            endcase
          end else if (prog_evt) begin
            // Normal or emergency ramp as configured
            s_d.ax[i].st = asa_pkg::ASA_S_DECEL;
            s_d.ax[i].cause = asa_pkg::ASA_C_PROG;
            s_d.ax[i].cnt = (s_q.ctrl[asa_pkg::CTRL_PROG +: 2] == 2'(asa_pkg::ASA_PROG_EMG))
                            ? ms_cyc(s_q.ax[i].edec) : ms_cyc(s_q.ndec);
          end else if (s_q.ax[i].st == asa_pkg::ASA_S_RUN) begin
            if (dec_rise[i]) begin
              // Rising request; pause replaces the stop; positioning only
              s_d.ax[i].st = (s_q.mode_eff && s_q.ax[i].op == asa_pkg::ASA_OP_POS)
                             ? asa_pkg::ASA_S_PDEC : asa_pkg::ASA_S_DECEL;
              s_d.ax[i].cause = asa_pkg::ASA_C_DEC;
              s_d.ax[i].cnt = ms_cyc(s_q.ndec);
            end else if (s_q.ax[i].op == asa_pkg::ASA_OP_POS) begin
              s_d.ax[i].left = s_q.ax[i].left - 32'h0000_0001;
              if (s_q.ax[i].left <= 32'h0000_0001) begin
                s_d.ax[i].st = asa_pkg::ASA_S_DWELL;
                s_d.ax[i].cnt = s_q.dwell;
              end
            end else if (s_q.ax[i].op == asa_pkg::ASA_OP_JOG) begin
              if (!s_q.jog[i]) begin
                s_d.ax[i].st = asa_pkg::ASA_S_DECEL;
                s_d.ax[i].cnt = ms_cyc(s_q.ndec);
              end
            end else if (creep_reached[i]) begin
              s_d.ax[i].handoff = 1'b1;
            end
          end else if (s_q.ax[i].st == asa_pkg::ASA_S_PDEC) begin
            // Pause ramp in the normal time, then paused
            s_d.ax[i].cnt = s_q.ax[i].cnt - 32'h0000_0001;
            if (s_q.ax[i].cnt == 32'h0000_0000) begin
              s_d.ax[i].st = asa_pkg::ASA_S_PAUSED;
            end
          end else if (!dec_g[i]) begin
            // Released request resumes the interrupted move
            s_d.ax[i].st = asa_pkg::ASA_S_RUN;
            s_d.ax[i].cause = asa_pkg::ASA_C_NONE;
          end
        end
        asa_pkg::ASA_S_DECEL: begin
          s_d.ax[i].pos = s_q.ax[i].pos + 32'h0000_0001;
          s_d.ax[i].cnt = s_q.ax[i].cnt - 32'h0000_0001;
          if (s_q.ax[i].cnt == 32'h0000_0000) begin
            // Flags at the end of the ramp; position kept
            s_d.ax[i].pos = s_q.ax[i].pos;
            s_d.ax[i].st = asa_pkg::ASA_S_HOLD;
            s_d.ax[i].busy = 1'b0;
            s_d.ax[i].done = 1'b1;
          end
          if (c == asa_pkg::ASA_C_SYS && s_q.ax[i].cause != asa_pkg::ASA_C_SYS) begin
            // System stop overrides a slower ramp; flags at once
            s_d.ax[i].cause = c;
            s_d.ax[i].cnt = sys_cyc;
            s_d.ax[i].busy = 1'b0;
            s_d.ax[i].done = 1'b1;
          end
        end
        asa_pkg::ASA_S_HOLD: begin
          // Held until every cause has cleared
          if (c == asa_pkg::ASA_C_NONE) begin
            s_d.ax[i].st = asa_pkg::ASA_S_IDLE;
            // Jog still requested after a fault stop runs again
            if (s_q.ax[i].op == asa_pkg::ASA_OP_JOG && s_q.jog[i] &&
                s_q.ax[i].cause == asa_pkg::ASA_C_ERR) begin
              s_d.ax[i].st = asa_pkg::ASA_S_RUN;
              s_d.ax[i].busy = 1'b1;
              s_d.ax[i].done = 1'b0;
            end
          end
        end
        asa_pkg::ASA_S_DWELL: begin
          s_d.ax[i].cnt = s_q.ax[i].cnt - 32'h0000_0001;
          // A stop cuts the dwell short; otherwise wait it out
          if (c != asa_pkg::ASA_C_NONE || prog_evt) begin
            s_d.ax[i].st = asa_pkg::ASA_S_HOLD;
            s_d.ax[i].cause = prog_evt ? asa_pkg::ASA_C_PROG : c;
            s_d.ax[i].busy = 1'b0;
            s_d.ax[i].done = 1'b1;
          end else if (s_q.ax[i].cnt == 32'h0000_0000) begin
            s_d.ax[i].st = asa_pkg::ASA_S_IDLE;
            s_d.ax[i].busy = 1'b0;
            s_d.ax[i].done = 1'b1;
          end
        end
        default: s_d.ax[i].st = asa_pkg::ASA_S_IDLE;
      endcase
      // Paused flag kept in a register so the port needs no decode
      s_d.ax[i].paused = s_d.ax[i].st == asa_pkg::ASA_S_PAUSED;
      if (s_q.ax[i].st != asa_pkg::ASA_S_IDLE && s_q.ax[i].st != asa_pkg::ASA_S_HOLD) begin
        all_still = 1'b0;
      end
    end
    // Mode selection adopted only while nothing moves
    if (all_still) begin
      s_d.mode_eff = s_q.ctrl[asa_pkg::CTRL_MODE];
    end
    // Sticky fault flag; a new fault beats a clear in the same clock
    if (wr_go && adr == asa_pkg::OFS_STAT && wb_sel_i[0] && wb_dat_i[asa_pkg::STAT_ERR]) begin
      s_d.err_flag = 1'b0;
    end
    if (any_fault) begin
      s_d.err_flag = 1'b1;
    end
    s_d.note = s_d.err_flag && s_q.ctrl[asa_pkg::CTRL_NOTE];
    // Read mux; unmapped reads return zero
    unique case (adr)
      asa_pkg::OFS_CTRL: rd = 32'(s_q.ctrl);
      asa_pkg::OFS_STAT: rd = {30'h0000_0000, s_q.err_flag, s_q.mode_eff};
      asa_pkg::OFS_EMG: rd = 32'(s_q.emg);
      asa_pkg::OFS_DEC: rd = 32'(s_q.dec);
      asa_pkg::OFS_JOG: rd = 32'(s_q.jog);
      asa_pkg::OFS_GROUP: rd = 32'(s_q.link);
      asa_pkg::OFS_MOVE: rd = s_q.move_len;
      asa_pkg::OFS_DWELL: rd = s_q.dwell;
      asa_pkg::OFS_NDEC: rd = 32'(s_q.ndec);
      default: rd = 32'h0000_0000;
    endcase
    for (int i = 0; i < N; i++) begin
      if (adr == asa_pkg::OFS_EDEC + 10'(4 * i)) rd = 32'(s_q.ax[i].edec);
      if (adr == asa_pkg::OFS_LDEC + 10'(4 * i)) rd = 32'(s_q.ax[i].ldec);
      if (adr == asa_pkg::OFS_RDEC + 10'(4 * i)) rd = 32'(s_q.ax[i].rdec);
      if (adr == asa_pkg::OFS_POS + 10'(4 * i)) rd = s_q.ax[i].pos;
      if (adr == asa_pkg::OFS_FLAGS) begin
        rd[i] = s_q.ax[i].busy;
        rd[asa_pkg::FLAGS_DONE + i] = s_q.ax[i].done;
      end
    end
    // One wait state: ack in the clock after the request, dropped a clock later
    s_d.ack = req && !s_q.ack;
    if (rd_go) begin
      s_d.rdat = rd;
    end
  end

  // State register with synchronous reset
  always_ff @(posedge sys_clk) begin
    if (!rst_b) begin
      s_q <= '0;
      s_q.ctrl <= asa_pkg::CTRL_RST;
      s_q.ndec <= asa_pkg::DEC_MS_RST;
      s_q.cpu_run_prev <= 1'b0;
      for (int i = 0; i < N; i++) begin
        // Stop times start at their default
        s_q.ax[i].edec <= asa_pkg::DEC_MS_RST;
        s_q.ax[i].ldec <= asa_pkg::DEC_MS_RST;
        s_q.ax[i].rdec <= asa_pkg::DEC_MS_RST;
      end
    end else begin
      s_q <= s_d;
    end
  end

  // Outputs straight from the state register
  assign wb_ack_o = s_q.ack;
  assign wb_dat_o = s_q.rdat;
  assign error_notify = s_q.note;
  for (genvar g = 0; g < N; g++) begin : g_out
    assign axis_busy[g] = s_q.ax[g].busy;
    assign axis_done[g] = s_q.ax[g].done;
    assign axis_paused[g] = s_q.ax[g].paused;
    assign servo_handoff[g] = s_q.ax[g].handoff;
  end
endmodule // asa_top
`default_nettype wire

// ### verif/asa_chk.sv
/*
  Port checker for the axis stop arbiter.
  Assumes the top's ports only; bound into every asa_top instance.
*/
`timescale 1ns/1ps
`default_nettype none
module asa_chk #(
  parameter int CYC_PER_MS = 4
) (
  // Watched ports
  input wire logic sys_clk,
  input wire logic rst_b,
  input wire logic wb_cyc_i,
  input wire logic wb_stb_i,
  input wire logic wb_ack_o,
  input wire logic system_halt_request_output,
  input wire logic [asa_pkg::AXES-1:0] limit_hit,
  input wire logic [asa_pkg::AXES-1:0] creep_reached,
  input wire logic [asa_pkg::AXES-1:0] axis_busy,
  input wire logic [asa_pkg::AXES-1:0] axis_done,
  input wire logic [asa_pkg::AXES-1:0] axis_paused,
  input wire logic [asa_pkg::AXES-1:0] servo_handoff
);
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (!rst_b);
  // Single-clock stop sequences
  sequence s_halt_on_run;
    $rose(system_halt_request_output) ##0 (axis_busy[0] && !servo_handoff[0]);
  endsequence
  sequence s_halt_in_pause;
    axis_paused[0] ##0 system_halt_request_output;
  endsequence
  property p_ack_pulse;
    wb_ack_o |=> !wb_ack_o;
  endproperty
  property p_ack_resp;
    wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o;
  endproperty
  property p_sys_done;
    s_halt_on_run |=> ##[0:1] (!axis_busy[0] && axis_done[0]);
  endproperty
  property p_pause_cancel;
    s_halt_in_pause |=> ##[0:1] !axis_paused[0];
  endproperty
  property p_start_refused;
    $rose(axis_busy[0]) |-> !$past(system_halt_request_output) && !$past(limit_hit[0]);
  endproperty
  property p_sys_hold;
    system_halt_request_output && !axis_busy[0] |=> !axis_busy[0];
  endproperty
  property p_flag_excl;
    (axis_busy & axis_done) == '0;
  endproperty
  property p_handoff;
    (servo_handoff & ~$past(servo_handoff) & ~$past(creep_reached)) == '0;
  endproperty
  a_ack_pulse: assert property (p_ack_pulse) else $error("ack longer than one cycle");
  a_ack_resp: assert property (p_ack_resp) else $error("bus request not answered");
  a_sys_done: assert property (p_sys_done) else $error("system stop flags late");
  a_pause_cancel: assert property (p_pause_cancel) else $error("pause kept");
  a_start_refused: assert property (p_start_refused) else $error("start under stop");
  a_sys_hold: assert property (p_sys_hold) else $error("axis left system stop");
  a_flag_excl: assert property (p_flag_excl) else $error("busy and done together");
  a_handoff: assert property (p_handoff) else $error("handoff before creep");
endmodule // asa_chk
bind asa_top asa_chk #(.CYC_PER_MS(CYC_PER_MS)) u_chk (.sys_clk(sys_clk), .rst_b(rst_b),
  .wb_cyc_i(wb_cyc_i), .wb_stb_i(wb_stb_i), .wb_ack_o(wb_ack_o),
  .system_halt_request_output(system_halt_request_output), .limit_hit(limit_hit),
  .creep_reached(creep_reached), .axis_busy(axis_busy), .axis_done(axis_done),
  .axis_paused(axis_paused), .servo_handoff(servo_handoff));
`default_nettype wire

// ### verif/asa_servo_model.sv
/*
  Servo amplifier side: limit and fault levels, soft limit held low, creep during home.
  Assumes the bench raises the request bits; creep follows busy in home mode.
*/
`timescale 1ns/1ps
`default_nettype none
module asa_servo_model (
  // Clock, bench requests and arbiter busy
  input wire logic sys_clk,
  input wire logic [3:0] lim_req,
  input wire logic [3:0] flt_req,
  input wire logic [3:0] home_req,
  input wire logic [3:0] axis_busy,
  // Levels toward the arbiter
  output logic [3:0] limit_hit,
  output logic [3:0] soft_limit_hit,
  output logic [3:0] axis_fault,
  output logic [3:0] creep_reached
);
  int cnt [4];
  // creep then release; the amplifier alone ends the home move
  always @(posedge sys_clk) begin
    for (int k = 0; k < 4; k++) begin
      cnt[k] <= (axis_busy[k] && home_req[k]) ? cnt[k] + 1 : 0;
      creep_reached[k] <= cnt[k] >= 10 && cnt[k] < 20;
    end
    limit_hit <= lim_req;
    soft_limit_hit <= 4'h0;
    axis_fault <= flt_req;
  end
endmodule // asa_servo_model
`default_nettype wire

// ### verif/tb_top.sv
/*
  Self-checking bench for the axis stop arbiter.
  Assumes a one-cycle registered Wishbone ack and CYC_PER_MS shortened to 4.
*/
`timescale 1ns/1ps
`default_nettype none
module tb_top;
  logic sys_clk = 0, rst_b = 0, cyc = 0, stb = 0, we = 0, halt = 0, cpu_run = 1;
  logic [9:0] adr = 10'h000;
  logic [31:0] dat = 32'h0, q, len;
  logic [3:0] lim = 4'h0, flt = 4'h0, home = 4'h0, lh, sl, af, cr, busy, done, paused, ho;
  logic ack, note;
  logic [31:0] rdat;
  int failures = 0, checks_done = 0, seed = 32'h0fef, t;
  always #2 sys_clk = ~sys_clk;
  asa_top #(.CYC_PER_MS(4)) dut (.sys_clk(sys_clk), .rst_b(rst_b), .wb_cyc_i(cyc),
    .wb_stb_i(stb), .wb_we_i(we), .wb_adr_i(adr), .wb_sel_i(4'hF), .wb_dat_i(dat),
    .wb_ack_o(ack), .wb_dat_o(rdat), .system_halt_request_output(halt), .limit_hit(lh),
    .soft_limit_hit(sl), .axis_fault(af), .creep_reached(cr), .cpu_run(cpu_run),
    .axis_busy(busy), .axis_done(done), .axis_paused(paused), .servo_handoff(ho),
    .error_notify(note));
  asa_servo_model u_servo (.sys_clk(sys_clk), .lim_req(lim), .flt_req(flt),
    .home_req(home), .axis_busy(busy), .limit_hit(lh), .soft_limit_hit(sl),
    .axis_fault(af), .creep_reached(cr));
  task end_sim();
    $display("checks %0d failures %0d", checks_done, failures);
    if (failures == 0 && checks_done > 0) $display("verification passed");
    else $display("verification failed");
    $finish;
  endtask
  task chk(input string n, input logic [31:0] e, input logic [31:0] g);
    checks_done++;
    if (g !== e) begin
      $display("Error %s expected %h seen %h", n, e, g);
      failures++;
    end
  endtask
  // One classic cycle; held until ack is sampled, then one idle cycle
  task wb(input logic w, input logic [9:0] a, input logic [31:0] d);
    int n;
    cyc <= 1;
    stb <= 1;
    we <= w;
    adr <= a;
    dat <= d;
    n = 0;
    do begin
      @(posedge sys_clk);
      n++;
    end while (ack !== 1'b1 && n < 50);
    q = rdat;
    cyc <= 0;
    stb <= 0;
    we <= 0;
    @(posedge sys_clk);
    if (n >= 50) begin
      failures++;
      end_sim();
    end
  endtask
  // Bounded wait for a status bit to reach a level; returns cycles spent
  task automatic wait_bit(ref logic [3:0] s, input int k, input logic v);
    t = 0;
    while (s[k] !== v && t < 5000) begin
      @(posedge sys_clk);
      t++;
    end
    if (t >= 5000) begin
      failures++;
      end_sim();
    end
  endtask
  initial begin
    repeat (4) @(posedge sys_clk);
    rst_b <= 1;
    @(posedge sys_clk);
    wb(0, asa_pkg::OFS_CTRL, 0);
    chk("ctrl", {27'h0, asa_pkg::CTRL_RST}, q);
    for (int i = 0; i < 4; i++) begin
      wb(0, asa_pkg::OFS_RDEC + 10'(4 * i), 0);
      chk("rdec", {18'h0, asa_pkg::DEC_MS_RST}, q);
      wb(0, asa_pkg::OFS_EDEC + 10'(4 * i), 0);
      chk("edec", {18'h0, asa_pkg::DEC_MS_RST}, q);
      wb(0, asa_pkg::OFS_LDEC + 10'(4 * i), 0);
      chk("ldec", {18'h0, asa_pkg::DEC_MS_RST}, q);
    end
    wb(1, asa_pkg::OFS_EDEC, 32'h00004E20);
    wb(0, asa_pkg::OFS_EDEC, 0);
    chk("edec clamp", {18'h0, asa_pkg::DEC_MS_MAX}, q);
    wb(0, 10'h3FC, 0);
    chk("unmapped", 32'h0, q);
    wb(1, asa_pkg::OFS_EDEC, 32'h00000002);
    wb(1, asa_pkg::OFS_DWELL, 32'h0);
    // Random-length move; position kept at rest
    len = 32'd20 + ($random(seed) & 32'h3F);
    wb(1, asa_pkg::OFS_MOVE, len);
    wb(1, asa_pkg::OFS_START, 32'h00000001);
    wait_bit(busy, 0, 0);
    chk("done", 1, done[0]);
    wb(0, asa_pkg::OFS_POS, 0);
    chk("pos", len, q);
    // Emergency stop lasts its own time, then start is refused
    wb(1, asa_pkg::OFS_MOVE, 32'h00000FA0);
    wb(1, asa_pkg::OFS_START, 32'h00000001);
    wb(1, asa_pkg::OFS_EMG, 32'h00000001);
    wait_bit(busy, 0, 0);
    chk("emg time", 1, t >= 8);
    wb(1, asa_pkg::OFS_START, 32'h00000001);
    chk("refused", 0, busy[0]);
    wb(1, asa_pkg::OFS_EMG, 32'h0);
    // Pause, resume, then cancel by system stop
    wb(1, asa_pkg::OFS_CTRL, 32'h00000017);
    wb(0, asa_pkg::OFS_STAT, 0);
    chk("mode", 1, q[0]);
    wb(1, asa_pkg::OFS_START, 32'h00000001);
    wb(1, asa_pkg::OFS_CTRL, 32'h00000016);
    wb(0, asa_pkg::OFS_STAT, 0);
    chk("mode frozen", 1, q[0]);
    wb(1, asa_pkg::OFS_DEC, 32'h00000001);
    wait_bit(paused, 0, 1);
    wb(1, asa_pkg::OFS_DEC, 32'h0);
    @(posedge sys_clk);
    chk("resumed", 2'b01, {paused[0], busy[0]});
    wb(1, asa_pkg::OFS_DEC, 32'h00000001);
    wait_bit(paused, 0, 1);
    halt <= 1;
    repeat (3) @(posedge sys_clk);
    chk("halted", 3'b001, {paused[0], busy[0], done[0]});
    halt <= 0;
    wb(1, asa_pkg::OFS_DEC, 32'h0);
    // The 1 ms system ramp must end before the axis counts as stopped
    repeat (8) @(posedge sys_clk);
    wb(0, asa_pkg::OFS_STAT, 0);
    chk("mode applied", 0, q[0]);
    // Grouped jog stopped by a limit on the follower
    wb(1, asa_pkg::OFS_GROUP, 32'h00000002);
    wb(1, asa_pkg::OFS_JOG, 32'h00000003);
    wb(1, asa_pkg::OFS_START, 32'h00010003);
    lim <= 4'h2;
    wait_bit(busy, 0, 0);
    chk("group stop", 0, busy[1]);
    lim <= 4'h0;
    repeat (3) @(posedge sys_clk);
    // Emergency on the leader's bit stops the follower in its own time
    wb(1, asa_pkg::OFS_START, 32'h00010003);
    wb(1, asa_pkg::OFS_EMG, 32'h00000001);
    wait_bit(busy, 1, 0);
    chk("group emg", 1, done[1]);
    wb(1, asa_pkg::OFS_EMG, 32'h0);
    // Fault with all-axes reaction and notification; held jog restarts
    wb(1, asa_pkg::OFS_START, 32'h00010001);
    flt <= 4'h8;
    wait_bit(busy, 0, 0);
    chk("notify", 1, note);
    flt <= 4'h0;
    wait_bit(busy, 0, 1);
    chk("jog restart", 0, done[0]);
    wb(1, asa_pkg::OFS_JOG, 32'h0);
    wait_bit(busy, 0, 0);
    // Home move handed to the servo
    home <= 4'h4;
    wb(1, asa_pkg::OFS_START, 32'h00020004);
    wait_bit(ho, 2, 1);
    wait_bit(busy, 2, 0);
    chk("home done", 1, done[2]);
    // Run to program ends a long move with the normal ramp
    wb(1, asa_pkg::OFS_START, 32'h00000001);
    cpu_run <= 0;
    wait_bit(busy, 0, 0);
    chk("prog stop", 1, t < 1000);
    end_sim();
  end
endmodule // tb_top
`default_nettype wire
